/* File: rtl/sem_host.sv */
`timescale 1ns/1ps
// Overview of operation
// - Writing zero requests a token; writing one from the same port releases.
// - Semaphore select low picks flag space; enable and read/write as plain RAM.
// - Between polls, deassert select or output enable to see fresh values.
// - Write zero then read back; only zero means ownership.
// - After failure, keep polling or withdraw with a one.
// - No power-up reset: software writes one to every flag first.
module sem_host
  import sem_host_pkg::*;
(
  input  wire logic                          i_clock,
  input  wire logic                          i_reset_n,
  input  wire logic                          i_cmd_valid,
  input  wire logic [1:0]                    i_cmd_op,
  input  wire logic [sem_host_pkg::INDEX_W-1:0] i_cmd_index,
  input  wire logic [sem_host_pkg::DATA_W-1:0]  i_data_in,
  output logic                               o_cmd_ready,
  output logic                               o_done,
  output logic                               o_owned,
  output logic [sem_host_pkg::ADDR_W-1:0]    o_address,
  output logic [sem_host_pkg::DATA_W-1:0]    o_data_out,
  output logic                               o_data_oe,
  output logic                               o_semaphore_select_n,
  output logic                               o_port_select_n,
  output logic                               o_output_enable_n,
  output logic                               o_read_write_n
);
  import sem_host_pkg::*;

  host_state_t                state_q;
  logic [3:0]                 count_q;
  logic [1:0]                 op_q;
  logic [INDEX_W-1:0]         index_q;
  logic                       wbit_q;
  logic [DATA_W-1:0]          data_sync;

  sem_pin_sync #(.WIDTH(DATA_W)) u_sync (
    .i_clock   (i_clock),
    .i_reset_n (i_reset_n),
    .i_async   (i_data_in),
    .o_sync    (data_sync)
  );

  // A read needs the flag low on every data bit; majority is not sought
  function automatic logic flag_low(input logic [DATA_W-1:0] d);
    flag_low = (d == '0);
  endfunction : flag_low

  // Sequencer: claim and poll read back after a write or alone
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      state_q <= ST_IDLE;
      count_q <= CNT_ZERO;
      op_q    <= CMD_POLL;
      index_q <= '0;
      wbit_q  <= 1'b1;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          if (i_cmd_valid)
          begin
            op_q    <= i_cmd_op;
            index_q <= i_cmd_index;
            wbit_q  <= (i_cmd_op != CMD_CLAIM);
            count_q <= STROBE_CNT;
            // Poll skips the write; claim writes then reads back
            state_q <= (i_cmd_op == CMD_POLL) ? ST_READ : ST_WRITE;
          end
        end
        ST_WRITE:
        begin
          if (count_q != 4'h1)
          begin
            count_q <= count_q - 4'h1;
          end
          else
          begin
            count_q <= GAP_CNT;
            state_q <= ST_GAP;
          end
        end
        ST_GAP:
        begin
          // Select released so the next read relatches the flag
          if (count_q != 4'h1)
          begin
            count_q <= count_q - 4'h1;
          end
          else if (op_q == CMD_CLAIM)
          begin
            count_q <= STROBE_CNT;
            state_q <= ST_READ;
          end
          else if (op_q == CMD_INIT && index_q != INDEX_W'(FLAG_COUNT - 1))
          begin
            index_q <= index_q + INDEX_W'(1);
            count_q <= STROBE_CNT;
            state_q <= ST_WRITE;
          end
          else
          begin
            state_q <= ST_DONE;
          end
        end
        ST_READ:
        begin
          if (count_q != 4'h1)
          begin
            count_q <= count_q - 4'h1;
          end
          else
          begin
            count_q <= GAP_CNT;
            // Marks a finished read so the result is taken in ST_DONE
            op_q    <= CMD_POLL;
            state_q <= ST_GAP;
          end
        end
        ST_DONE:
        begin
          state_q <= ST_IDLE;
        end
        default:
        begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Pin drive; all outputs registered; strobes from the current state, address and data from index_q and wbit_q, one cycle behind
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_address            <= '0;
      o_data_out           <= '1;
      o_data_oe            <= 1'b0;
      o_semaphore_select_n <= 1'b1;
      o_port_select_n      <= 1'b1;
      o_output_enable_n    <= 1'b1;
      o_read_write_n       <= 1'b1;
    end
    else
    begin
      o_port_select_n <= 1'b1;
      o_address       <= {{(ADDR_W - INDEX_W){1'b0}}, index_q};
      o_data_out      <= {{(DATA_W - 1){1'b1}}, wbit_q};
      case (state_q)
        ST_WRITE:
        begin
          o_semaphore_select_n <= 1'b0;
          o_read_write_n       <= 1'b0;
          o_output_enable_n    <= 1'b1;
          o_data_oe            <= 1'b1;
        end
        ST_READ:
        begin
          o_semaphore_select_n <= 1'b0;
          o_read_write_n       <= 1'b1;
          o_output_enable_n    <= 1'b0;
          o_data_oe            <= 1'b0;
        end
        default:
        begin
          o_semaphore_select_n <= 1'b1;
          o_read_write_n       <= 1'b1;
          o_output_enable_n    <= 1'b1;
          o_data_oe            <= 1'b0;
        end
      endcase
    end
  end

  // Result; the two sync stages put read data two cycles behind the pins,
  // so the flag is taken in ST_DONE, together with the done pulse
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_owned     <= 1'b0;
      o_done      <= 1'b0;
      o_cmd_ready <= 1'b0;
    end
    else
    begin
      o_done      <= (state_q == ST_DONE);
      o_cmd_ready <= (state_q == ST_IDLE) && !i_cmd_valid;
      if (state_q == ST_DONE && op_q == CMD_POLL)
      begin
        o_owned <= flag_low(data_sync);
      end
      else if (state_q == ST_WRITE && wbit_q)
      begin
        o_owned <= 1'b0;
      end
    end
  end
endmodule : sem_host

/* File: rtl/sem_host_pkg.sv */
package sem_host_pkg;
  localparam int          ADDR_W          = 13;
  localparam int          DATA_W          = 8;
  localparam int          FLAG_COUNT      = 8;
  localparam int          INDEX_W         = 3;
  localparam int          CLOCK_MHZ       = 25;
  // Strobe low time and recovery gap, in ns as the host drives them
  localparam int          STROBE_NS       = 80;
  localparam int          GAP_NS          = 40;
  localparam int          STROBE_CYCLES   = (STROBE_NS * CLOCK_MHZ + 999) / 1000;
  localparam int          GAP_CYCLES      = (GAP_NS * CLOCK_MHZ + 999) / 1000;
  localparam logic [3:0]  STROBE_CNT      = 4'(STROBE_CYCLES);
  localparam logic [3:0]  GAP_CNT         = 4'(GAP_CYCLES);
  localparam logic [3:0]  CNT_ZERO        = 4'h0;
  localparam logic [1:0]  CMD_CLAIM       = 2'h0;
  localparam logic [1:0]  CMD_RELEASE     = 2'h1;
  localparam logic [1:0]  CMD_POLL        = 2'h2;
  localparam logic [1:0]  CMD_INIT        = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_WRITE = 3'b001,
    ST_GAP   = 3'b011,
    ST_READ  = 3'b010,
    ST_DONE  = 3'b110
  } host_state_t;
endpackage : sem_host_pkg

/* File: rtl/sem_pin_sync.sv */
`timescale 1ns/1ps
module sem_pin_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             i_clock,
  input  wire logic             i_reset_n,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] stage_q;

  // Two flops; only the second is read
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      stage_q <= '0;
      o_sync  <= '0;
    end
    else
    begin
      stage_q <= i_async;
      o_sync  <= stage_q;
    end
  end
endmodule : sem_pin_sync

/* File: verif/sem_dev_model.sv */
`timescale 1ns/1ps
module sem_dev_model (
  input  wire logic        i_clock,
  input  wire logic        i_sem_n,
  input  wire logic        i_oe_n,
  input  wire logic        i_rw_n,
  input  wire logic [12:0] i_addr,
  input  wire logic [7:0]  i_data,
  input  wire logic        i_far_we,
  input  wire logic [2:0]  i_far_idx,
  input  wire logic        i_far_bit,
  output logic      [7:0]  o_data,
  output logic      [7:0]  o_far_flag
);
  // Owner: 0 free, 1 host, 2 far; request latches start as zeros, no reset
  logic [1:0] own [8] = '{default: 2'h0};
  logic [7:0] req_h   = 8'h00;
  logic [7:0] req_f   = 8'h00;
  logic       lat     = 1'h1;
  wire        rd_n    = i_sem_n | i_oe_n;
  always @(posedge i_clock)
  begin
    if (!i_sem_n && !i_rw_n) req_h[i_addr[2:0]] = i_data[0];
    if (i_far_we) req_f[i_far_idx] = i_far_bit;
    for (int i = 0; i < 8; i++)
    begin
      if ((own[i] == 2'h1 && req_h[i]) || (own[i] == 2'h2 && req_f[i])) own[i] = 2'h0;
      if (own[i] == 2'h0) own[i] = !req_h[i] ? 2'h1 : (!req_f[i] ? 2'h2 : 2'h0);
      o_far_flag[i] = own[i] != 2'h2;
    end
  end
  always @(negedge rd_n) lat = own[i_addr[2:0]] != 2'h1;
  // Released bus shows the inverse, so a late sample never passes as a read
  assign o_data = rd_n ? {8{!lat}} : {8{lat}};
endmodule : sem_dev_model

/* File: verif/sem_host_assertions.sv */
`timescale 1ns/1ps
module sem_host_chk (
  input wire logic        i_clock,
  input wire logic        i_reset_n,
  input wire logic        o_owned,
  input wire logic [12:0] o_address,
  input wire logic [7:0]  o_data_out,
  input wire logic        o_semaphore_select_n,
  input wire logic        o_port_select_n,
  input wire logic        o_output_enable_n,
  input wire logic        o_read_write_n
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  a_ram_idle: assert property (o_port_select_n)
    else $error("ram selected");
  a_write_sel: assert property (!o_read_write_n |-> !o_semaphore_select_n && o_output_enable_n)
    else $error("bad write");
  a_addr_high: assert property (!o_semaphore_select_n |-> o_address[12:3] == 10'h000)
    else $error("high address");
  a_data_high: assert property (!o_read_write_n |-> o_data_out[7:1] == 7'h7F)
    else $error("high data");
  // A read that follows a read without select or enable released between them would see the old latch
  a_read_gap: assert property ($fell(o_output_enable_n) |-> $past(o_semaphore_select_n))
    else $error("no gap");
  a_strobe_two: assert property ($fell(o_semaphore_select_n) |=> !o_semaphore_select_n ##1 o_semaphore_select_n)
    else $error("strobe");
  a_release_drop: assert property (!o_read_write_n && o_data_out[0] |=> !o_owned)
    else $error("owned kept");
  a_owned_read: assert property ($rose(o_owned) |-> !$past(o_output_enable_n) || !$past(o_output_enable_n, 2))
    else $error("owned early");
endmodule : sem_host_chk
bind sem_host sem_host_chk u_chk (.i_clock(i_clock), .i_reset_n(i_reset_n), .o_owned(o_owned),
  .o_address(o_address), .o_data_out(o_data_out), .o_semaphore_select_n(o_semaphore_select_n),
  .o_port_select_n(o_port_select_n), .o_output_enable_n(o_output_enable_n),
  .o_read_write_n(o_read_write_n));

/* File: verif/sem_host_bench.sv */
`timescale 1ns/1ps
module sem_host_bench;
  import sem_host_pkg::*;
  logic clk, rst_n, vld, rdy, dn, own, doe, sn, oen, rwn, fwe, fb;
  logic [1:0] op;
  logic [2:0] ix, fi;
  logic [12:0] ad;
  logic [7:0] dq, md, ff;
  int fail_count = 0;
  int checks_done = 0;
  int cyc = 0;
  wire [7:0] bus = doe ? dq : md;
  sem_host uut (.i_clock(clk), .i_reset_n(rst_n), .i_cmd_valid(vld), .i_cmd_op(op),
    .i_cmd_index(ix), .i_data_in(bus), .o_cmd_ready(rdy), .o_done(dn), .o_owned(own),
    .o_address(ad), .o_data_out(dq), .o_data_oe(doe), .o_semaphore_select_n(sn),
    .o_port_select_n(), .o_output_enable_n(oen), .o_read_write_n(rwn));
  sem_dev_model dev (.i_clock(clk), .i_sem_n(sn), .i_oe_n(oen), .i_rw_n(rwn), .i_addr(ad),
    .i_data(bus), .i_far_we(fwe), .i_far_idx(fi), .i_far_bit(fb), .o_data(md), .o_far_flag(ff));
  initial
  begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  // Tests need under 400 cycles; a hang is cut well before the run grows long
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      fail_count++;
      end_of_test();
    end
  end
  task end_of_test;
    $display("checks %0d fails %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
      $display("Error %0t got %h want %h", $time, got, exp);
    if (got !== exp)
      fail_count++;
  endtask : chk
  task run(input logic [1:0] o, input logic [2:0] i);
    int n;
    @(posedge clk);
    for (n = 0; rdy !== 1'h1 && n < 40; n++) @(posedge clk);
    chk(8'(rdy), 8'h01);
    vld <= 1'h1;
    op <= o;
    ix <= i;
    @(posedge clk);
    vld <= 1'h0;
    for (n = 0; dn !== 1'h1 && n < 40; n++) @(posedge clk);
    chk(8'(dn), 8'h01);
  endtask : run
  task far(input logic [2:0] i, input logic b);
    fwe <= 1'h1;
    fi <= i;
    fb <= b;
    @(posedge clk);
    fwe <= 1'h0;
    @(posedge clk);
  endtask : far
  task t_init;
    run(CMD_INIT, 3'h0);
    for (int i = 0; i < 8; i++) far(3'(i), 1'h1);
    chk(ff, 8'hFF);
    $display("init end");
  endtask : t_init
  task t_contend;
    run(CMD_CLAIM, 3'h3);
    chk(8'(own), 8'h01);
    far(3'h5, 1'h0);
    run(CMD_CLAIM, 3'h5);
    chk(8'(own), 8'h00);
    far(3'h5, 1'h1);
    run(CMD_POLL, 3'h5);
    chk(8'(own), 8'h01);
    run(CMD_RELEASE, 3'h5);
    chk(8'(own), 8'h00);
    $display("contend end");
  endtask : t_contend
  task t_release;
    run(CMD_RELEASE, 3'h3);
    far(3'h3, 1'h0);
    far(3'h5, 1'h0);
    run(CMD_POLL, 3'h3);
    chk(8'(own), 8'h00);
    chk(ff, 8'hD7);
    // Two reads in a row of the same value catch a result taken before the data settles
    run(CMD_POLL, 3'h5);
    chk(8'(own), 8'h00);
    $display("release end");
  endtask : t_release
  initial
  begin
    rst_n = 1'h0;
    vld = 1'h0;
    op = 2'h0;
    ix = 3'h0;
    fwe = 1'h0;
    fi = 3'h0;
    fb = 1'h0;
    repeat (20) @(posedge clk);
    rst_n <= 1'h1;
    repeat (2) @(posedge clk);
    t_init;
    t_contend;
    t_release;
    end_of_test;
  end
endmodule : sem_host_bench
